// [design/hpd_regs.sv]
// APB register bank for hub port disable and current-consumption configuration
//
// Overview of operation
// RULE1 - disable mask bit zero leaves a port available, one disables it
// RULE2 - bus-powered with remap off: flagged ports stay disabled, never enumerable
// RULE3 - report only the enabled port count and renumber active ports contiguously
// RULE4 - any combination and order of disabled ports works correctly
// RULE5 - with the built-in default configuration, disabled ports come from strap pins
// RULE6 - bit 2 controls port 2, bit 1 port 1; others reserved
// RULE7 - self-powered max power holds upstream draw in 2 mA units
// RULE8 - configurer includes a zero-reporting embedded peripheral in max power values
// RULE9 - bus-powered max power holds upstream draw in 2 mA units
// RULE10 - self-powered controller current excludes attached compound peripheral, 2 mA units
// RULE11 - configurer keeps self-powered power values at or under 100 mA
// RULE12 - with remap selected, disable registers are ignored for the remap map
// RULE13 - bus-powered register used when bus-powered, self-powered register otherwise
`include "hpd_defs.svh"
`timescale 1ns/10ps
`default_nettype none
module hpd_regs
  import hpd_pkg::*;
#(
  parameter int PORTS = 2
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // pins and hub status
  input wire logic [PORTS-1:0] port_off_strap_pins,
  input wire logic self_powered_pin,
  input wire logic [PORTS-1:0] port_remap_off,
  // effective configuration towards the hub core
  output logic [PORTS-1:0] port_off,
  output logic [PORTS*4-1:0] port_logical_num,
  output logic [3:0] enabled_port_count,
  output logic [7:0] reported_max_draw,
  output logic [7:0] controller_self_pwr_draw,
  output logic self_power_over_limit
);

  initial begin
    if (PORTS != 2) begin
      $error("hpd_regs: the register layout serves exactly two ports");
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  typedef struct packed {
    hpd_apb_state_t apb;
    logic [31:0] rdata;
    logic err;
    logic [7:0] self_port_disable;
    logic [7:0] bus_port_disable;
    logic [7:0] self_pwr_max_draw;
    logic [7:0] bus_pwr_max_draw;
    logic [7:0] ctrl_draw;
    logic port_remap_select;
    logic default_config;
    logic [PORTS-1:0] off;
    logic [PORTS*4-1:0] lnum;
    logic [3:0] count;
    logic [7:0] max_draw;
    logic [7:0] ctrl_out;
    logic over_limit;
  } hpd_regs_state_t;

  hpd_regs_state_t state;
  hpd_regs_state_t next_state;

  logic [PORTS-1:0] straps_sync;
  logic self_pwr_sync;
  logic [PORTS-1:0] remap_sync;
  logic [PORTS-1:0] sel_off;
  logic [PORTS*4-1:0] map_num;
  logic [3:0] map_count;
  hpd_src_t src;

  ////////////////////////////////////////////////////////////////////////////
  // pins pass two flops before use

  hpd_sync2 #(.WIDTH(2 * PORTS + 1)) u_sync (
    .clock(clock),
    .rst_n(rst_n),
    .async_in({port_off_strap_pins, port_remap_off, self_powered_pin}),
    .sync_out({straps_sync, remap_sync, self_pwr_sync})
  );

  ////////////////////////////////////////////////////////////////////////////
  // disable source selection

  always_comb begin
    if (state.port_remap_select) begin
      src = hpd_src_remap; // see RULE12
    end else if (state.default_config) begin
      src = hpd_src_straps; // see RULE5
    end else if (self_pwr_sync) begin
      src = hpd_src_self_reg; // see RULE13
    end else begin
      src = hpd_src_bus_reg; // see RULE13
    end
  end

  always_comb begin
    case (src)
      hpd_src_bus_reg: begin
        // bit n of the register gates port n; one means off; see RULE1 see RULE2 see RULE6
        sel_off = {state.bus_port_disable[`HPD_BIT_PORT2],
                   state.bus_port_disable[`HPD_BIT_PORT1]};
      end
      hpd_src_self_reg: begin
        sel_off = {state.self_port_disable[`HPD_BIT_PORT2],
                   state.self_port_disable[`HPD_BIT_PORT1]};
      end
      hpd_src_straps: sel_off = straps_sync;
      // the remap map is kept elsewhere; only its off bits reach this block
      hpd_src_remap: sel_off = remap_sync;
      default: sel_off = '0;
    endcase
  end

  // contiguous renumbering for any disabled combination; see RULE3 see RULE4
  hpd_port_map #(.PORTS(PORTS)) u_map (
    .port_off(sel_off),
    .logical_num(map_num),
    .enabled_count(map_count)
  );

  ////////////////////////////////////////////////////////////////////////////
  // apb access and state update

  always_comb begin
    logic [9:0] idx;
    logic [7:0] wbyte;
    logic hit;
    idx = paddr[11:2];
    wbyte = pwdata[7:0];
    hit = 1'b1;
    next_state = state;
    next_state.apb = hpd_apb_idle;

    if (psel && !penable) begin
      // setup cycle: decode, and answer in the following access cycle
      next_state.apb = hpd_apb_done;
      next_state.rdata = 32'h0000_0000;
      case (idx)
        10'(`HPD_IDX_SELF_PORT_DISABLE): next_state.rdata[7:0] = state.self_port_disable;
        10'(`HPD_IDX_BUS_PORT_DISABLE): next_state.rdata[7:0] = state.bus_port_disable;
        10'(`HPD_IDX_SELF_MAX_POWER): next_state.rdata[7:0] = state.self_pwr_max_draw;
        10'(`HPD_IDX_BUS_MAX_POWER): next_state.rdata[7:0] = state.bus_pwr_max_draw;
        10'(`HPD_IDX_CTRL_CURRENT_SELF): next_state.rdata[7:0] = state.ctrl_draw;
        10'(`HPD_IDX_HUB_MODE): begin
          next_state.rdata[`HPD_BIT_REMAP_SELECT] = state.port_remap_select;
          next_state.rdata[`HPD_BIT_DEFAULT_CONFIG] = state.default_config;
        end
        10'(`HPD_IDX_PORT_STATUS): begin
          next_state.rdata[PORTS-1:0] = state.off;
          next_state.rdata[7:4] = state.count;
          next_state.rdata[8] = state.over_limit;
          next_state.rdata[9] = self_pwr_sync;
        end
        default: hit = 1'b0;
      endcase
      // unmapped index, or a write to the read-only status word, is refused
      next_state.err = !hit || (pwrite && (idx == 10'(`HPD_IDX_PORT_STATUS)));
    end

    // a write lands only at the access edge, where the master sees pready high
    if ((state.apb == hpd_apb_done) && psel && penable && !state.err) begin
      if (pwrite && pstrb[0]) begin
        case (idx)
          10'(`HPD_IDX_SELF_PORT_DISABLE): begin
            next_state.self_port_disable = wbyte & `HPD_PORT_FIELD_MASK;
          end
          10'(`HPD_IDX_BUS_PORT_DISABLE): begin
            // reserved bits are not stored and read as zero; see RULE6
            next_state.bus_port_disable = wbyte & `HPD_PORT_FIELD_MASK;
          end
          10'(`HPD_IDX_SELF_MAX_POWER): next_state.self_pwr_max_draw = wbyte; // see RULE7
          10'(`HPD_IDX_BUS_MAX_POWER): next_state.bus_pwr_max_draw = wbyte; // see RULE9
          10'(`HPD_IDX_CTRL_CURRENT_SELF): next_state.ctrl_draw = wbyte; // see RULE10
          10'(`HPD_IDX_HUB_MODE): begin
            next_state.port_remap_select = wbyte[`HPD_BIT_REMAP_SELECT];
            next_state.default_config = wbyte[`HPD_BIT_DEFAULT_CONFIG];
          end
          default: next_state.err = state.err;
        endcase
      end
    end

    // effective configuration, registered so that outputs come from flops
    next_state.off = sel_off;
    next_state.lnum = map_num;
    next_state.count = map_count;
    // the host is told the draw that matches the present power mode; see RULE7 see RULE9
    next_state.max_draw = self_pwr_sync ? state.self_pwr_max_draw : state.bus_pwr_max_draw;
    next_state.ctrl_out = state.ctrl_draw; // see RULE10
    // the limit is the configurer's duty; this flag only shows a breach
    next_state.over_limit =
      (state.self_pwr_max_draw > 8'(`HPD_SELF_POWER_LIMIT_CODE)) ||
      (state.ctrl_draw > 8'(`HPD_SELF_POWER_LIMIT_CODE));

    if (!rst_n) begin
      next_state = '0;
      next_state.apb = hpd_apb_idle;
      next_state.self_port_disable = `HPD_RST_PORT_DISABLE;
      next_state.bus_port_disable = `HPD_RST_PORT_DISABLE;
      next_state.self_pwr_max_draw = `HPD_RST_POWER;
      next_state.bus_pwr_max_draw = `HPD_RST_POWER;
      next_state.ctrl_draw = `HPD_RST_POWER;
      {next_state.default_config, next_state.port_remap_select} = 2'(`HPD_RST_HUB_MODE);
    end
  end

  always_ff @(posedge clock) begin
    state <= next_state;
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs from the state flops; pslverr ands the error flop with the done state

  assign prdata = state.rdata;
  assign pready = (state.apb == hpd_apb_done);
  assign pslverr = (state.apb == hpd_apb_done) && state.err;
  assign port_off = state.off;
  assign port_logical_num = state.lnum;
  assign enabled_port_count = state.count;
  assign reported_max_draw = state.max_draw;
  assign controller_self_pwr_draw = state.ctrl_out;
  assign self_power_over_limit = state.over_limit;

endmodule : hpd_regs
`default_nettype wire

// [design/hpd_defs.svh]
// offsets, field positions, reset values and limits of the hub port-disable and power registers
`ifndef HPD_DEFS_SVH
`define HPD_DEFS_SVH

// register indices as printed; byte address is four times the index
`define HPD_IDX_SELF_PORT_DISABLE 8'h0A
`define HPD_IDX_BUS_PORT_DISABLE 8'h0B
`define HPD_IDX_SELF_MAX_POWER 8'h0C
`define HPD_IDX_BUS_MAX_POWER 8'h0D
`define HPD_IDX_CTRL_CURRENT_SELF 8'h0E
`define HPD_IDX_HUB_MODE 8'h20
`define HPD_IDX_PORT_STATUS 8'h21

// field positions
`define HPD_BIT_PORT1 1
`define HPD_BIT_PORT2 2
`define HPD_BIT_REMAP_SELECT 0
`define HPD_BIT_DEFAULT_CONFIG 1
`define HPD_BIT_SELF_POWERED 2
`define HPD_PORT_FIELD_MASK 8'h06

// reset values
`define HPD_RST_PORT_DISABLE 8'h00
`define HPD_RST_POWER 8'h00
`define HPD_RST_HUB_MODE 8'h00

// power values are in 2 mA units; the bus standard caps the self-powered ones at 100 mA
`define HPD_POWER_UNIT_MA 2
`define HPD_SELF_POWER_LIMIT_MA 100
`define HPD_SELF_POWER_LIMIT_CODE (`HPD_SELF_POWER_LIMIT_MA / `HPD_POWER_UNIT_MA)

`endif

// [design/hpd_pkg.sv]
// types shared by the hub port-disable and power register block
package hpd_pkg;

  typedef enum logic [1:0] {
    hpd_src_bus_reg,
    hpd_src_self_reg,
    hpd_src_straps,
    hpd_src_remap
  } hpd_src_t;

  typedef enum logic {
    hpd_apb_idle,
    hpd_apb_done
  } hpd_apb_state_t;

endpackage : hpd_pkg

// [design/hpd_sync2.sv]
// two-flop synchroniser for asynchronous pin levels
`timescale 1ns/10ps
`default_nettype none
module hpd_sync2 #(
  parameter int WIDTH = 2
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // asynchronous level in, synchronised level out
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } hpd_sync_state_t;

  hpd_sync_state_t state;
  hpd_sync_state_t next_state;

  initial begin
    if (WIDTH < 1) begin
      $error("hpd_sync2: WIDTH must be at least 1");
    end
  end

  always_comb begin
    next_state.meta = async_in;
    next_state.stable = state.meta;
    if (!rst_n) begin
      next_state = '0;
    end
  end

  always_ff @(posedge clock) begin
    state <= next_state;
  end

  assign sync_out = state.stable;

endmodule : hpd_sync2
`default_nettype wire

// [design/hpd_port_map.sv]
// maps the disabled-port mask to a contiguous logical port order and an enabled count
`timescale 1ns/10ps
`default_nettype none
module hpd_port_map #(
  parameter int PORTS = 2
) (
  // physical ports, bit n-1 is downstream port n; one means the port is off
  input wire logic [PORTS-1:0] port_off,
  // logical number reported to the host for each physical port, zero when off
  output logic [PORTS*4-1:0] logical_num,
  // number of enabled ports reported to the host
  output logic [3:0] enabled_count
);

  initial begin
    if (PORTS < 1 || PORTS > 15) begin
      $error("hpd_port_map: PORTS must be 1 to 15");
    end
  end

  // each active port is numbered after the active ports below it, so any
  // combination of disabled ports still reports contiguous numbers
  genvar g;
  generate
    for (g = 0; g < PORTS; g++) begin : g_port
      always_comb begin
        logic [3:0] below;
        below = 4'h0;
        for (int k = 0; k < g; k++) begin
          below = below + {3'h0, ~port_off[k]};
        end
        logical_num[g*4 +: 4] = port_off[g] ? 4'h0 : below + 4'h1;
      end
    end
  endgenerate

  always_comb begin
    enabled_count = 4'h0;
    for (int k = 0; k < PORTS; k++) begin
      enabled_count = enabled_count + {3'h0, ~port_off[k]};
    end
  end

endmodule : hpd_port_map
`default_nettype wire

// [test/hpd_host_model.sv]
// upstream host model that enumerates the ports the hub reports
`timescale 1ns/10ps
`default_nettype none
module hpd_host_model (
  // hub view
  input wire logic [1:0] port_off,
  input wire logic [7:0] port_logical_num,
  // enumeration result
  output logic [3:0] enum_count,
  output logic fault
);
  always_comb begin
    enum_count = 4'h0;
    fault = 1'b0;
    for (int i = 0; i < 2; i++) begin
      if (port_logical_num[i*4+:4] != 4'h0) enum_count = enum_count + 4'h1;
      if (port_off[i] && port_logical_num[i*4+:4] != 4'h0) fault = 1'b1;
    end
    // two live ports sharing a number would collide during enumeration
    if (port_logical_num[3:0] != 4'h0 && port_logical_num[3:0] == port_logical_num[7:4]) fault = 1'b1;
  end
endmodule : hpd_host_model
`default_nettype wire

// [test/hpd_regs_props.sv]
// assertions on the ports of the hub port-disable register block
`timescale 1ns/10ps
`default_nettype none
module hpd_regs_props #(
  parameter int PORTS = 2
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // configuration
  input wire logic [PORTS-1:0] port_off,
  input wire logic [PORTS*4-1:0] port_logical_num,
  input wire logic [3:0] enabled_port_count,
  input wire logic [7:0] controller_self_pwr_draw
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  logic [1:0] up;
  wire logic setup = psel && !penable;
  wire logic rd_dis = setup && !pwrite && paddr == 12'h02C;
  wire logic wr_ctl = setup && pwrite && pstrb[0] && paddr == 12'h038;
  wire logic [7:0] wbyte = pwdata[7:0];
  wire logic live = up == 2'h3;
  // outputs stay zero just after reset, so relations wait a few edges
  always_ff @(posedge clock) begin
    if (!rst_n) up <= 2'h0;
    else if (up != 2'h3) up <= up + 2'h1;
  end
  ready_after_setup_a: assert property (setup |=> pready) else $error("no ready after setup");
  ready_pulse_a: assert property (pready |=> !pready) else $error("ready held too long");
  ready_cause_a: assert property (pready |-> $past(setup)) else $error("ready without setup");
  err_needs_ready_a: assert property (pslverr |-> pready) else $error("error without ready");
  off_num_zero_a: assert property (live |-> (!port_off[0] || port_logical_num[3:0] == 4'h0)
    && (!port_off[1] || port_logical_num[7:4] == 4'h0)) else $error("off port numbered");
  count_match_a: assert property (live |-> enabled_port_count == 4'(PORTS - $countones(port_off)))
    else $error("count wrong");
  contiguous_num_a: assert property (live |-> (port_off[0] || port_logical_num[3:0] == 4'h1)
    && (port_off[1] || port_logical_num[7:4] == (port_off[0] ? 4'h1 : 4'h2)))
    else $error("numbers not contiguous");
  reserved_zero_a: assert property (pready && !pslverr && $past(rd_dis) |-> (prdata & 32'hFFFFFFF9) == 32'h0)
    else $error("reserved bits set");
  ctrl_draw_a: assert property (wr_ctl |-> ##3 controller_self_pwr_draw == $past(wbyte, 3))
    else $error("controller draw not updated");
  cover property (wr_ctl);
  cover property (pslverr);
  cover property (live && port_off == 2'h3);
endmodule : hpd_regs_props
`default_nettype wire

// [test/tb_top.sv]
// top testbench of the hub port-disable and power register block
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic clock = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rdat, tmp, seed = 32'hB8EA;
  logic [3:0] pstrb = 4'hF, enabled_port_count, hcnt;
  logic pready, pslverr, err, hfault, self_power_over_limit, self_powered_pin = 1'b0;
  logic [1:0] port_off_strap_pins = 2'h0, port_remap_off = 2'h0, port_off;
  logic [7:0] port_logical_num, reported_max_draw, controller_self_pwr_draw, a, c;
  int failures = 0;
  int num_checks = 0;
  always #50 clock = ~clock;
  hpd_regs #(.PORTS(2)) i_hpd_regs (.clock, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb, .prdata, .pready, .pslverr, .port_off_strap_pins, .self_powered_pin, .port_remap_off,
    .port_off, .port_logical_num, .enabled_port_count, .reported_max_draw,
    .controller_self_pwr_draw, .self_power_over_limit);
  hpd_host_model i_hpd_host_model (.port_off, .port_logical_num, .enum_count(hcnt), .fault(hfault));
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function automatic logic [7:0] exp_num(input logic [1:0] off);
    return {off[1] ? 4'h0 : (off[0] ? 4'h1 : 4'h2), off[0] ? 4'h0 : 4'h1};
  endfunction : exp_num
  task automatic summarize();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : summarize
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // one idle edge before each setup keeps every signal to one assignment per step
  task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
    int n;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'h0, idx, 2'h0};
    pwdata <= {rnd()} & 32'hFFFFFF00 | {24'h0, d};
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      failures++;
      summarize();
    end
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d);
  endtask : wr
  task automatic rd(input logic [7:0] idx, input logic [7:0] e, input logic ee);
    apb(1'b0, idx, 8'h00);
    chk(rdat, {24'h0, e});
    chk({31'h0, err}, {31'h0, ee});
  endtask : rd
  task automatic cfg(input logic [1:0] off);
    repeat (4) @(posedge clock);
    chk({30'h0, port_off}, {30'h0, off});
    chk({28'h0, enabled_port_count}, 32'(2 - $countones(off)));
    chk({24'h0, port_logical_num}, {24'h0, exp_num(off)});
    chk({27'h0, hfault, hcnt}, 32'(2 - $countones(off)));
  endtask : cfg
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    for (int i = 11; i <= 14; i++) rd(8'(i), 8'h00, 1'b0);
    // reserved bits written at random must read back as zero
    for (int v = 0; v < 4; v++) begin
      tmp = rnd();
      wr(8'h0B, tmp[7:0] & 8'hF9 | 8'(v << 1));
      rd(8'h0B, 8'(v << 1), 1'b0);
      cfg(2'(v));
    end
    for (int i = 0; i < 8; i++) begin
      tmp = rnd();
      a = tmp[7:0] % 8'h33;
      c = tmp[23:16] % 8'h33;
      wr(8'h0C, a);
      wr(8'h0D, tmp[15:8]);
      wr(8'h0E, c);
      self_powered_pin <= tmp[24];
      repeat (4) @(posedge clock);
      chk({24'h0, reported_max_draw}, {24'h0, tmp[24] ? a : tmp[15:8]});
      chk({24'h0, controller_self_pwr_draw}, {24'h0, c});
      rd(8'h0D, tmp[15:8], 1'b0);
    end
    // 100 mA boundary is 50 units: flagged above it, not at it
    for (int i = 0; i < 3; i++) begin
      wr(i == 2 ? 8'h0E : 8'h0C, i == 1 ? 8'h32 : 8'h33);
      if (i == 0) wr(8'h0E, 8'h00);
      repeat (4) @(posedge clock);
      chk({31'h0, self_power_over_limit}, {31'h0, i != 1});
    end
    self_powered_pin <= 1'b1;
    wr(8'h0A, 8'h04);
    wr(8'h0B, 8'h02);
    cfg(2'h2);
    self_powered_pin <= 1'b0;
    cfg(2'h1);
    port_off_strap_pins <= 2'h2;
    wr(8'h20, 8'h02);
    cfg(2'h2);
    port_remap_off <= 2'h3;
    wr(8'h20, 8'h03);
    cfg(2'h3);
    rd(8'h30, 8'h00, 1'b1);
    summarize();
  end
endmodule : tb_top
bind hpd_regs hpd_regs_props #(.PORTS(PORTS)) i_hpd_regs_props (.clock, .rst_n, .psel, .penable,
  .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .port_off, .port_logical_num,
  .enabled_port_count, .controller_self_pwr_draw);
`default_nettype wire
